// file: rtl/pbm_defs.svh
// register offsets, field positions and reset values for the port b mux
`ifndef PBM_DEFS_SVH
`define PBM_DEFS_SVH
`define PBM_ADDR_W 5
`define PBM_OFF_MCU_CONTROL 5'h00
`define PBM_OFF_PORT_OUT 5'h04
`define PBM_OFF_PORT_DIR 5'h08
`define PBM_OFF_PIN_IN 5'h0c
`define PBM_CTRL_W 5
`define PBM_CTRL_RESET 5'h00
`define PBM_PORT_RESET 8'h00
`define PBM_PUD_BIT 4
`define PBM_RESP_OKAY 2'h0
`define PBM_RESP_SLVERR 2'h2
`endif

// file: rtl/pbm_pkg.sv
// types for the port b alternate function mux
package pbm_pkg;
    typedef struct packed {
        logic [4:0] ctrl;
        logic [7:0] port_out;
        logic [7:0] dir;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic aw_got;
        logic w_got;
        logic [4:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pbm_state_t;
endpackage

// file: rtl/pbm_port_mux.sv
// port b alternate function override mux with axi4-lite register slave
`timescale 1ns/1ps
`include "pbm_defs.svh"
module pbm_port_mux
    import pbm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] pad_in,
    output logic [7:0] pullup_en,
    output logic [7:0] drive_en,
    output logic [7:0] drive_val,
    input wire logic sleep_clamp,
    input wire logic spi_enable_bit,
    input wire logic spi_master_select,
    input wire logic spi_miso_out,
    input wire logic spi_sck_out,
    input wire logic spi_mosi_out,
    output logic spi_miso_in,
    output logic spi_sck_in,
    output logic spi_mosi_in,
    input wire logic stage2_out0_enable,
    input wire logic stage2_out0,
    input wire logic stage2_out1_enable,
    input wire logic stage2_out1,
    input wire logic stage2_out2_enable,
    input wire logic stage2_out2,
    input wire logic stage2_out3_enable,
    input wire logic stage2_out3,
    input wire logic aux_stage_out1_enable,
    input wire logic aux_stage_out1,
    input wire logic comparator3_out_enable,
    input wire logic comparator3_out,
    input wire logic ext_irq0_enabled,
    input wire logic ext_irq1_enabled,
    input wire logic adc9_digital_off,
    input wire logic adc8_digital_off,
    input wire logic adc5_digital_off,
    input wire logic adc3_digital_off,
    input wire logic adc2_digital_off,
    output logic timer1_capture_in,
    output logic timer1_count_in,
    output logic ext_irq0_in,
    output logic ext_irq1_in
);
    pbm_state_t q;
    pbm_state_t d;
    logic global_pullup_off;
    logic spi_master;
    logic spi_slave;
    logic [7:0] pullup_override_en;
    logic [7:0] pullup_override_val;
    logic [7:0] dir_override_en;
    logic [7:0] dir_override_val;
    logic [7:0] value_override_en;
    logic [7:0] value_override_val;
    logic [7:0] input_en_override_en;
    logic [7:0] input_en_override_val;
    logic [7:0] input_en;
    logic [7:0] pin_in;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_strb;

    // decode a byte address to a register index, bit 2 flags a hit
    function automatic logic [2:0] reg_sel(input logic [4:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        case ({addr[4:2], 2'h0})
            `PBM_OFF_MCU_CONTROL: sel = 3'h4;
            `PBM_OFF_PORT_OUT: sel = 3'h5;
            `PBM_OFF_PORT_DIR: sel = 3'h6;
            `PBM_OFF_PIN_IN: sel = 3'h7;
            default: sel = 3'h0;
        endcase
        return sel;
    endfunction

    assign global_pullup_off = q.ctrl[`PBM_PUD_BIT];
    assign spi_master = spi_enable_bit & spi_master_select;
    assign spi_slave = spi_enable_bit & ~spi_master_select;

    // per-pin override sources, purely combinational
    always_comb begin
        pullup_override_en = 8'h00;
        pullup_override_val = 8'h00;
        dir_override_en = 8'h00;
        dir_override_val = 8'h00;
        value_override_en = 8'h00;
        value_override_val = 8'h00;
        input_en_override_en = 8'h00;
        input_en_override_val = 8'h00;
        // pin 7: stage2 output 2, capture input, adc9
        dir_override_en[7] = stage2_out2_enable;
        dir_override_val[7] = 1'b1;
        value_override_en[7] = stage2_out2_enable;
        value_override_val[7] = stage2_out2;
        input_en_override_en[7] = adc9_digital_off;
        // pin 6: spi miso, input when master
        pullup_override_en[6] = spi_master;
        pullup_override_val[6] = q.port_out[6] & ~global_pullup_off;
        dir_override_en[6] = spi_master;
        value_override_en[6] = spi_slave;
        value_override_val[6] = spi_miso_out;
        input_en_override_en[6] = adc8_digital_off;
        // pin 5: spi clock, input when slave; irq1 keeps input alive
        pullup_override_en[5] = spi_slave;
        pullup_override_val[5] = q.port_out[5] & ~global_pullup_off;
        dir_override_en[5] = spi_slave;
        value_override_en[5] = spi_master;
        value_override_val[5] = spi_sck_out;
        input_en_override_en[5] = adc5_digital_off | ext_irq1_enabled;
        input_en_override_val[5] = ext_irq1_enabled;
        // pin 4: spi mosi, input when slave
        pullup_override_en[4] = spi_slave;
        pullup_override_val[4] = q.port_out[4] & ~global_pullup_off;
        dir_override_en[4] = spi_slave;
        value_override_en[4] = spi_master;
        value_override_val[4] = spi_mosi_out;
        input_en_override_en[4] = adc3_digital_off;
        // pin 3: aux stage output 1, adc2
        dir_override_en[3] = aux_stage_out1_enable;
        dir_override_val[3] = 1'b1;
        value_override_en[3] = aux_stage_out1_enable;
        value_override_val[3] = aux_stage_out1;
        input_en_override_en[3] = adc2_digital_off;
        // pin 2: stage2 output 1, irq0
        dir_override_en[2] = stage2_out1_enable;
        dir_override_val[2] = 1'b1;
        value_override_en[2] = stage2_out1_enable;
        value_override_val[2] = stage2_out1;
        input_en_override_en[2] = ext_irq0_enabled;
        input_en_override_val[2] = ext_irq0_enabled;
        // pin 1: stage2 output 0
        dir_override_en[1] = stage2_out0_enable;
        dir_override_val[1] = 1'b1;
        value_override_en[1] = stage2_out0_enable;
        value_override_val[1] = stage2_out0;
        // pin 0: stage2 output 3 before comparator 3
        dir_override_en[0] = stage2_out3_enable | comparator3_out_enable;
        dir_override_val[0] = 1'b1;
        value_override_en[0] = stage2_out3_enable | comparator3_out_enable;
        if (stage2_out3_enable) begin
            value_override_val[0] = stage2_out3;
        end else if (comparator3_out_enable) begin
            value_override_val[0] = comparator3_out;
        end else begin
            value_override_val[0] = 1'b0;
        end
    end

    // generic override cell applied to every pin
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pullup_override_en[i]) begin
                pullup_en[i] = pullup_override_val[i];
            end else begin
                pullup_en[i] = ~q.dir[i] & q.port_out[i] & ~global_pullup_off;
            end
            drive_en[i] = dir_override_en[i] ? dir_override_val[i] : q.dir[i];
            drive_val[i] = value_override_en[i] ? value_override_val[i] : q.port_out[i];
            input_en[i] = input_en_override_en[i] ? input_en_override_val[i] : ~sleep_clamp;
        end
    end

    assign pin_in = q.sync2 & input_en;
    assign timer1_capture_in = pin_in[7];
    assign spi_miso_in = pin_in[6];
    assign spi_sck_in = pin_in[5];
    assign ext_irq1_in = pin_in[5];
    assign spi_mosi_in = pin_in[4];
    assign ext_irq0_in = pin_in[2];
    assign timer1_count_in = pin_in[0];

    // axi4-lite handshakes
    assign s_axi_awready = ~q.aw_got & ~q.bvalid;
    assign s_axi_wready = ~q.w_got & ~q.bvalid;
    assign s_axi_arready = ~q.rvalid;
    assign aw_fire = s_axi_awvalid & s_axi_awready;
    assign w_fire = s_axi_wvalid & s_axi_wready;
    assign ar_fire = s_axi_arvalid & s_axi_arready;
    assign wr_addr = q.aw_got ? q.awaddr : s_axi_awaddr;
    assign wr_data = q.w_got ? q.wdata : s_axi_wdata[7:0];
    assign wr_strb = q.w_got ? q.wstrb0 : s_axi_wstrb[0];
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    always_comb begin
        logic [2:0] wsel;
        logic [2:0] rsel;
        wsel = reg_sel(wr_addr);
        rsel = reg_sel(s_axi_araddr);
        d = q;
        d.sync1 = pad_in;
        d.sync2 = q.sync1;
        if (aw_fire) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (w_fire) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata[7:0];
            d.wstrb0 = s_axi_wstrb[0];
        end
        if ((q.aw_got | aw_fire) & (q.w_got | w_fire)) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wsel[2] ? `PBM_RESP_OKAY : `PBM_RESP_SLVERR;
            if (wr_strb) begin
                case (wsel)
                    3'h4: d.ctrl = wr_data[4:0];
                    3'h5: d.port_out = wr_data;
                    3'h6: d.dir = wr_data;
                    default: d.ctrl = q.ctrl;
                endcase
            end
        end
        if (q.bvalid & s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (ar_fire) begin
            d.rvalid = 1'b1;
            d.rresp = rsel[2] ? `PBM_RESP_OKAY : `PBM_RESP_SLVERR;
            case (rsel)
                3'h4: d.rdata = {27'h0, q.ctrl};
                3'h5: d.rdata = {24'h0, q.port_out};
                3'h6: d.rdata = {24'h0, q.dir};
                3'h7: d.rdata = {24'h0, pin_in};
                default: d.rdata = 32'h0;
            endcase
        end else if (q.rvalid & s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence spi_as_master;
        spi_enable_bit && spi_master_select;
    endsequence
    sequence spi_as_slave;
        spi_enable_bit && !spi_master_select;
    endsequence

    pud_blocks_pullups_a: assert property (global_pullup_off |-> pullup_en == 8'h00)
        else $error("pull-up on while global pull-up off");
    ctrl_reset_zero_a: assert property ($past(rst) |-> s_axi_bvalid == 1'b0 && q.ctrl == 5'h00)
        else $error("control not zero after reset");
    miso_forced_in_a: assert property (spi_as_master |-> !drive_en[6])
        else $error("pin 6 driven while spi master");
    miso_pullup_kept_a: assert property (spi_as_master |->
        pullup_en[6] == (q.port_out[6] & !global_pullup_off))
        else $error("pin 6 pull-up wrong while forced");
    sck_forced_in_a: assert property (spi_as_slave |-> !drive_en[5])
        else $error("pin 5 driven while spi slave");
    mosi_forced_in_a: assert property (spi_as_slave |->
        !drive_en[4] && pullup_en[4] == (q.port_out[4] & !global_pullup_off))
        else $error("pin 4 not forced input");
    sck_value_a: assert property (spi_as_master |-> drive_val[5] == spi_sck_out)
        else $error("pin 5 not carrying spi clock");
    pin7_stage_out_a: assert property (stage2_out2_enable |->
        drive_en[7] && drive_val[7] == stage2_out2)
        else $error("pin 7 not driving stage2 out2");
    capture_gated_a: assert property (adc9_digital_off |-> !timer1_capture_in)
        else $error("capture input not disabled");
    irq1_awake_a: assert property (ext_irq1_enabled |-> ext_irq1_in == q.sync2[5])
        else $error("irq1 input clamped while enabled");
    irq0_pad_path_a: assert property (ext_irq0_enabled && $stable(pad_in[2]) [*3] |->
        ext_irq0_in == pad_in[2])
        else $error("irq0 does not follow pin 2");
    pin3_aux_out_a: assert property (aux_stage_out1_enable |->
        drive_en[3] && drive_val[3] == aux_stage_out1)
        else $error("pin 3 not driving aux output");
    pin2_stage_out_a: assert property (stage2_out1_enable |->
        drive_en[2] && drive_val[2] == stage2_out1)
        else $error("pin 2 not driving stage2 out1");
    pin1_stage_out_a: assert property (stage2_out0_enable |->
        drive_en[1] && drive_val[1] == stage2_out0)
        else $error("pin 1 not driving stage2 out0");
    pin0_priority_a: assert property (comparator3_out_enable && !stage2_out3_enable |->
        drive_en[0] && drive_val[0] == comparator3_out)
        else $error("pin 0 comparator path wrong");
    count_input_a: assert property (!sleep_clamp |-> timer1_count_in == q.sync2[0])
        else $error("timer1 count input wrong");
    sleep_clamps_a: assert property (sleep_clamp && !ext_irq1_enabled |-> !ext_irq1_in)
        else $error("sleep clamp not applied");
    dir_follows_reg_a: assert property (!spi_enable_bit && !stage2_out0_enable |->
        drive_en[1] == q.dir[1] && drive_en[6:4] == q.dir[6:4])
        else $error("direction bit not in control");
endmodule

// file: test/pbm_periph_model.sv
// peripheral side model: spi, stage controllers, comparator, irq, adc and sleep levels
`timescale 1ns/1ps
module pbm_periph_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic [24:0] cfg,
    output logic [24:0] periph
);
    logic [24:0] cfg_q;
    initial begin
        cfg_q = 25'h0;
        periph = 25'h0;
    end
    // peripherals update their enables on the clock, promptly or one cycle late
    always @(posedge clk) begin
        cfg_q <= cfg;
        periph <= slow ? cfg_q : cfg;
    end
endmodule

// file: test/tb.sv
// self-checking testbench for the port b mux
`timescale 1ns/1ps
module tb;
    import pbm_pkg::*;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, chk = 1'b0;
    logic [4:0] awaddr = 5'h0, araddr = 5'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] pad = 8'h0, pu, de, dv, ctrl_m, out_m, dir_m;
    logic [24:0] cfg = 25'h0, p;
    logic mi, si, mo, cap, cnt, q0, q1;
    logic [39:0] expq[$];
    int num_errors = 0, num_checks = 0, cycles = 0;
    always #5 clk = ~clk;
    pbm_periph_model model (.clk(clk), .slow(slow), .cfg(cfg), .periph(p));
    pbm_port_mux dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad),
        .pullup_en(pu), .drive_en(de), .drive_val(dv), .sleep_clamp(p[24]),
        .spi_enable_bit(p[0]), .spi_master_select(p[1]), .spi_miso_out(p[2]),
        .spi_sck_out(p[3]), .spi_mosi_out(p[4]), .spi_miso_in(mi), .spi_sck_in(si),
        .spi_mosi_in(mo), .stage2_out0_enable(p[5]), .stage2_out0(p[6]),
        .stage2_out1_enable(p[7]), .stage2_out1(p[8]), .stage2_out2_enable(p[9]),
        .stage2_out2(p[10]), .stage2_out3_enable(p[11]), .stage2_out3(p[12]),
        .aux_stage_out1_enable(p[13]), .aux_stage_out1(p[14]),
        .comparator3_out_enable(p[15]), .comparator3_out(p[16]), .ext_irq0_enabled(p[17]),
        .ext_irq1_enabled(p[18]), .adc9_digital_off(p[19]), .adc8_digital_off(p[20]),
        .adc5_digital_off(p[21]), .adc3_digital_off(p[22]), .adc2_digital_off(p[23]),
        .timer1_capture_in(cap), .timer1_count_in(cnt), .ext_irq0_in(q0), .ext_irq1_in(q1));

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // monitor: each result that appears is compared with the oldest expectation
    task automatic take(input logic [39:0] got);
        logic [39:0] e;
        num_checks++;
        e = (expq.size() > 0) ? expq.pop_front() : ~got;
        if (got !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, e);
        end
    endtask
    always @(posedge clk) begin
        if (bvalid && bready) take({38'h0, bresp});
        if (rvalid && rready) take({6'h0, rresp, rdata});
        if (chk) take({9'h0, mi, si, mo, pu, de, dv & de, cap, cnt, q0, q1});
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
        expq.push_back({38'h0, (a > 5'h0c) ? 2'h2 : 2'h0});
        if (a <= 5'h0c && s[0]) begin
            if (a == 5'h00) ctrl_m = {3'h0, d[4:0]};
            if (a == 5'h04) out_m = d[7:0];
            if (a == 5'h08) dir_m = d[7:0];
        end
        while (!(ad && wd)) begin
            @(posedge clk);
            if (!ad && awready) begin ad = 1'b1; awvalid <= 1'b0; end
            if (!wd && wready) begin wd = 1'b1; wvalid <= 1'b0; end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        @(posedge clk);
    endtask

    // expected digital input enables per pin from peripheral levels
    function automatic logic [7:0] ien();
        return {~cfg[19] & ~cfg[24], ~cfg[20] & ~cfg[24], cfg[18] | (~cfg[21] & ~cfg[24]),
            ~cfg[22] & ~cfg[24], ~cfg[23] & ~cfg[24], cfg[17] | ~cfg[24], ~cfg[24],
            ~cfg[24]};
    endfunction

    task automatic rd(input logic [4:0] a);
        logic [7:0] v;
        v = (a == 5'h00) ? ctrl_m : (a == 5'h04) ? out_m : (a == 5'h08) ? dir_m :
            (a == 5'h0c) ? (pad & ien()) : 8'h0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        expq.push_back({6'h0, (a > 5'h0c) ? 2'h2 : 2'h0, 24'h0, v});
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // expected pin controls from register mirrors, peripheral levels and pads
    task automatic pins();
        logic [7:0] u, e, v, m;
        logic pd, sm, ss;
        repeat (4) @(posedge clk);
        pd = ctrl_m[4];
        m = ien();
        sm = cfg[0] & cfg[1];
        ss = cfg[0] & ~cfg[1];
        u = ~dir_m & out_m & {8{~pd}};
        e = dir_m;
        v = out_m;
        if (sm) begin e[6] = 1'b0; u[6] = out_m[6] & ~pd; v[5] = cfg[3]; v[4] = cfg[4]; end
        if (ss) begin e[5:4] = 2'b00; u[5:4] = out_m[5:4] & {2{~pd}}; v[6] = cfg[2]; end
        if (cfg[9]) begin e[7] = 1'b1; v[7] = cfg[10]; end
        if (cfg[13]) begin e[3] = 1'b1; v[3] = cfg[14]; end
        if (cfg[7]) begin e[2] = 1'b1; v[2] = cfg[8]; end
        if (cfg[5]) begin e[1] = 1'b1; v[1] = cfg[6]; end
        if (cfg[11] | cfg[15]) begin e[0] = 1'b1; v[0] = cfg[11] ? cfg[12] : cfg[16]; end
        expq.push_back({9'h0, pad[6:4] & m[6:4], u, e, v & e, pad[7] & ~cfg[19] & ~cfg[24],
            pad[0] & ~cfg[24],
            pad[2] & (cfg[17] | ~cfg[24]), pad[5] & (cfg[18] | (~cfg[21] & ~cfg[24]))});
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
    endtask

    initial begin
        ctrl_m = 8'h0;
        out_m = 8'h0;
        dir_m = 8'h0;
        void'($urandom(31551));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(5'h00);
        rd(5'h04);
        rd(5'h08);
        wr(5'h00, 32'hffffffff, 4'hf);
        rd(5'h00);
        wr(5'h10, 32'h0000001f, 4'hf);
        rd(5'h1c);
        wr(5'h04, 32'h000000ff, 4'h0);
        rd(5'h04);
        wr(5'h08, 32'h00000000, 4'hf);
        wr(5'h04, 32'h000000bf, 4'hf);
        pins();
        wr(5'h00, 32'h00000000, 4'hf);
        pins();
        for (int i = 0; i < 300; i++) begin
            wr(5'h04, $urandom, 4'hf);
            wr(5'h08, $urandom, 4'hf);
            wr(5'h00, $urandom, 4'hf);
            cfg <= 25'($urandom);
            pad <= 8'($urandom);
            slow <= 1'($urandom);
            @(posedge clk);
            pins();
            rd(5'h0c);
            rd(5'($urandom) & 5'h0c);
        end
        complete_run();
    end
endmodule
